// File: tb/bwp_pin_model.sv
// Pin world outside the port: far-end driver, pull-up resistors, floating lines
`timescale 1ns/1ns
module bwp_pin_model (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    logic [7:0] float_r = 8'h55;
    // Floating lines wander so a stale value is never read as valid
    always @(posedge clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pullup[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = float_r[i];
        end
    end
endmodule : bwp_pin_model

// File: tb/byte_wide_data_bus_io_port_tb.sv
// Self-checking bench for the byte-wide data bus I/O port
`timescale 1ns/1ns
`include "bwp_cfg.svh"
`define CK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module byte_wide_data_bus_io_port_tb;
    localparam logic [17:0] A_DIR = 18'(`BWP_IDX_DIR) << 2;
    localparam logic [17:0] A_LVL = 18'(`BWP_IDX_LVL) << 2;
    localparam logic [17:0] A_OUT = 18'(`BWP_IDX_OUT) << 2;
    localparam logic [17:0] A_PUL = 18'(`BWP_IDX_PUL) << 2;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rv;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, last_err, bus_16bit = 0, ext_data_oe = 0;
    logic hw_standby = 0, sw_standby = 0, manual_reset = 0;
    logic [2:0] mode_code = 3'h7;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_data_in;
    logic [7:0] ext_data_out = '0, ext_en = 8'hFF, ext_val = 8'h52;
    int miscompares = 0, samples_checked = 0;

    bwp_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_code(mode_code), .bus_16bit(bus_16bit),
        .hw_standby(hw_standby), .sw_standby(sw_standby), .manual_reset(manual_reset),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in));
    bwp_pin_model pins_u (.clk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    initial forever #10 pclk = ~pclk;

    task report_and_stop;
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    // Entered just after a rising edge; leaves one idle edge after the sampling edge
    task xfer(input logic w, input logic [17:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
        rv = prdata;
        last_err = pslverr;
        if (n >= 16) miscompares++;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : xfer

    task rd_ck(input logic [17:0] a, input logic [7:0] e);
        xfer(0, a, 8'h00);
        `CK("read", {24'h0, e}, rv)
    endtask : rd_ck

    task t_reset;
        rd_ck(A_DIR, `BWP_UNDEF_RD);
        rd_ck(A_OUT, `BWP_RST_OUT);
        rd_ck(A_PUL, `BWP_RST_PUL);
        rd_ck(A_LVL, 8'h52);
        `CK("oe", 8'h00, pin_oe)
        `CK("pull", 8'h00, pin_pullup)
        xfer(0, 18'h0, 8'h00);
        `CK("err", 1'b1, last_err)
    endtask : t_reset

    task t_gpio;
        ext_en <= 8'h0F;
        xfer(1, A_DIR, 8'hF0);
        xfer(1, A_OUT, 8'hA5);
        // part has program memory, pull-ups allowed
        xfer(1, A_PUL, 8'hFF);
        // readback register is not a write target
        xfer(1, A_LVL, 8'h00);
        wt(4);
        `CK("oe", 8'hF0, pin_oe)
        `CK("out", 8'hA0, pin_out & pin_oe)
        `CK("pull", 8'h0F, pin_pullup)
        rd_ck(A_OUT, 8'hA5);
        rd_ck(A_PUL, 8'hFF);
        rd_ck(A_LVL, 8'hA2);
        ext_en <= 8'h07;
        wt(4);
        rd_ck(A_LVL, 8'hAA);
    endtask : t_gpio

    task t_modes;
        for (int m = 4; m <= 6; m++) begin
            mode_code <= 3'(m);
            bus_16bit <= 0;
            wt(4);
            `CK("oe8", 8'hF0, pin_oe)
            `CK("pull8", 8'h0F, pin_pullup)
            bus_16bit <= 1; ext_en <= 8'h00; ext_data_out <= 8'hC3; ext_data_oe <= 1;
            wt(4);
            `CK("oe16", 8'hFF, pin_oe)
            `CK("out16", 8'hC3, pin_out)
            `CK("pull16", 8'h00, pin_pullup)
            ext_data_oe <= 0; ext_en <= 8'hFF; ext_val <= 8'h96;
            wt(5);
            `CK("oein", 8'h00, pin_oe)
            `CK("din", 8'h96, ext_data_in)
        end
        mode_code <= 3'h7; bus_16bit <= 0; ext_en <= 8'h07; ext_val <= 8'h52;
        wt(4);
        `CK("oe7", 8'hF0, pin_oe)
        mode_code <= 3'h2;
        wt(4);
        `CK("oeidle", 8'h00, pin_oe)
        `CK("pullidle", 8'h00, pin_pullup)
        mode_code <= 3'h7;
        wt(5);
    endtask : t_modes

    task t_freeze;
        for (int k = 0; k < 2; k++) begin
            {manual_reset, sw_standby} <= k ? 2'b10 : 2'b01;
            wt(2);
            ext_val <= 8'h5D;
            xfer(1, A_OUT, 8'h00);
            xfer(1, A_PUL, 8'h00);
            wt(4);
            rd_ck(A_LVL, 8'hAA);
            rd_ck(A_OUT, 8'hA5);
            `CK("fpull", 8'h0F, pin_pullup)
            `CK("foe", 8'hF0, pin_oe)
            {manual_reset, sw_standby} <= 2'b00; ext_val <= 8'h52;
            wt(5);
        end
        ext_en <= 8'hFF;
        hw_standby <= 1;
        wt(5);
        `CK("hoe", 8'h00, pin_oe)
        `CK("hpull", 8'h00, pin_pullup)
        rd_ck(A_OUT, 8'h00);
        rd_ck(A_PUL, 8'h00);
        rd_ck(A_LVL, 8'h52);
        hw_standby <= 0;
        wt(4);
        `CK("roe", 8'h00, pin_oe)
    endtask : t_freeze

    initial begin
        wt(5);
        presetn <= 1;
        @(posedge pclk);
        wt(4);
        t_reset();
        t_gpio();
        t_modes();
        t_freeze();
        report_and_stop();
    end

    initial begin
        #200000;
        miscompares++;
        report_and_stop();
    end
endmodule : byte_wide_data_bus_io_port_tb

// File: verilog/bwp_cfg.svh
// Constants for the byte-wide data bus I/O port
`ifndef BWP_CFG_SVH
`define BWP_CFG_SVH
`define BWP_W 8
`define BWP_AW 18
`define BWP_DW 32
`define BWP_IDX_W 16
`define BWP_IDX_DIR 16'hFEBD
`define BWP_IDX_LVL 16'hFF5D
`define BWP_IDX_OUT 16'hFF6D
`define BWP_IDX_PUL 16'hFF74
`define BWP_RST_DIR 8'h00
`define BWP_RST_OUT 8'h00
`define BWP_RST_PUL 8'h00
`define BWP_UNDEF_RD 8'hFF
`define BWP_MODE_EXT_LO 3'h4
`define BWP_MODE_EXT_HI 3'h6
`define BWP_MODE_GPIO 3'h7
`endif

// File: verilog/bwp_pkg.sv
// Types shared by the byte-wide data bus I/O port
package bwp_pkg;
    typedef enum logic [1:0] {
        BWP_ROLE_IDLE = 2'b00,
        BWP_ROLE_GPIO = 2'b01,
        BWP_ROLE_DBUS = 2'b10
    } bwp_role_e;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pull;
    } bwp_pins_s;
endpackage : bwp_pkg

// File: verilog/bwp_port.sv
// Byte-wide data bus I/O port with APB register access
`timescale 1ns/1ns
`include "bwp_cfg.svh"

// Functional notes
// RL1 - Direction register write-only, reads undefined
// RL2 - Direction cleared by reset, hardware standby
// RL3 - Mode 7: direction bit picks pin drive
// RL4 - Modes 4-6, 8-bit bus: general I/O
// RL5 - Modes 4-6, 16-bit bus: data bus pins
// RL6 - Output latch read/write, cleared like direction
// RL7 - Readback register read-only, writes ignored
// RL8 - Readback gives latch or pin per bit
// RL9 - Readback held in manual reset, software standby
// RL10 - Pull-up enable read/write, cleared like direction
// RL11 - Pull-up only for inputs in GPIO role
// RL12 - Pull-ups off on 16-bit bus, standby
// RL13 - Pull-up state kept over manual reset, standby
// RL14 - Software sets no pull-up without program memory; not modelled, no program-memory gate on pull-up writes
// RL15 - Mode and bus width re-evaluated continuously
module bwp_port import bwp_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] mode_code,
    input wire logic bus_16bit,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic manual_reset,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    input wire logic [7:0] ext_data_out,
    input wire logic ext_data_oe,
    output logic [7:0] ext_data_in
);
    logic [7:0] pin_s;
    logic [7:0] dir_r;
    logic [7:0] dir_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    logic [7:0] pul_r;
    logic [7:0] pul_nxt;
    logic [7:0] lvl_r;
    logic [7:0] lvl_nxt;
    bwp_pins_s pins_r;
    bwp_pins_s pins_nxt;
    logic [7:0] ext_in_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic pslverr_nxt;
    bwp_role_e role;

    bwp_sync2 u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d(pin_in),
        .q(pin_s)
    );

    // Address decode; every register byte address sits at four times its index
    wire [15:0] idx = paddr[17:2];
    wire aligned = (paddr[1:0] == 2'h0);
    wire hit_dir = aligned && (idx == `BWP_IDX_DIR);
    wire hit_lvl = aligned && (idx == `BWP_IDX_LVL);
    wire hit_out = aligned && (idx == `BWP_IDX_OUT);
    wire hit_pul = aligned && (idx == `BWP_IDX_PUL);
    wire hit_any = hit_dir || hit_lvl || hit_out || hit_pul;
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable && pready_r;
    // Manual reset and software standby freeze state; hardware standby wins
    wire freeze = (manual_reset || sw_standby) && !hw_standby;
    wire wr_ok = access_ph && pwrite && pstrb[0] && !freeze && !hw_standby;
    // RL7 readback has no write strobe
    wire wr_dir = wr_ok && hit_dir;
    wire wr_out = wr_ok && hit_out;
    wire wr_pul = wr_ok && hit_pul;

    // RL15 role from mode and width
    wire ext_mode = (mode_code >= `BWP_MODE_EXT_LO) && (mode_code <= `BWP_MODE_EXT_HI);
    wire gpio_mode = (mode_code == `BWP_MODE_GPIO);
    // RL4 narrow bus keeps general I/O
    assign role = (gpio_mode || (ext_mode && !bus_16bit)) ? BWP_ROLE_GPIO :
                  (ext_mode && bus_16bit) ? BWP_ROLE_DBUS : BWP_ROLE_IDLE;

    // RL2 clear in hardware standby
    assign dir_nxt = hw_standby ? `BWP_RST_DIR : (wr_dir ? pwdata[7:0] : dir_r);
    // RL6 output latch update
    assign out_nxt = hw_standby ? `BWP_RST_OUT : (wr_out ? pwdata[7:0] : out_r);
    // RL10 pull-up enable update
    assign pul_nxt = hw_standby ? `BWP_RST_PUL : (wr_pul ? pwdata[7:0] : pul_r);

    // RL8 latch for outputs, pin for inputs
    assign lvl_nxt = (dir_r & out_r) | (~dir_r & pin_s);

    // Pin drive per role; an unused mode code leaves every pin an input
    always_comb begin
        pins_nxt = '0;
        // RL12 hardware standby forces inputs
        if (!hw_standby) begin
            unique case (role)
                // RL3 direction selects drive
                BWP_ROLE_GPIO: begin
                    pins_nxt.out = out_r;
                    pins_nxt.oe = dir_r;
                    // RL11 pull-up on inputs only
                    pins_nxt.pull = ~dir_r & pul_r;
                end
                // RL5 direction ignored on wide bus
                BWP_ROLE_DBUS: begin
                    pins_nxt.out = ext_data_out;
                    pins_nxt.oe = {8{ext_data_oe}};
                    pins_nxt.pull = 8'h00;
                end
                BWP_ROLE_IDLE: begin
                    pins_nxt = '0;
                end
                default: begin
                    pins_nxt = '0;
                end
            endcase
        end
    end

    // RL1 direction reads undefined
    always_comb begin
        prdata_nxt = '0;
        if (hit_dir) begin
            prdata_nxt[7:0] = `BWP_UNDEF_RD;
        end else if (hit_lvl) begin
            prdata_nxt[7:0] = lvl_r;
        end else if (hit_out) begin
            prdata_nxt[7:0] = out_r;
        end else if (hit_pul) begin
            prdata_nxt[7:0] = pul_r;
        end
    end
    assign pslverr_nxt = !hit_any;

    // RL2 power-on clear of direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= `BWP_RST_DIR;
            out_r <= `BWP_RST_OUT;
            pul_r <= `BWP_RST_PUL;
        end else begin
            dir_r <= dir_nxt;
            out_r <= out_nxt;
            pul_r <= pul_nxt;
        end
    end

    // RL9 readback held while frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_r <= 8'h00;
        end else if (!freeze) begin
            lvl_r <= lvl_nxt;
        end
    end

    // RL13 pin state kept while frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_r <= '0;
        end else if (!freeze) begin
            pins_r <= pins_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_in_r <= 8'h00;
        end else begin
            ext_in_r <= pin_s;
        end
    end

    // Zero-wait slave: ready is raised for exactly the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= setup_ph;
            pslverr_r <= setup_ph && pslverr_nxt;
            if (setup_ph && !pwrite) begin
                prdata_r <= prdata_nxt;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign pin_out = pins_r.out;
    assign pin_oe = pins_r.oe;
    assign pin_pullup = pins_r.pull;
    assign ext_data_in = ext_in_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup_rd_dir;
        psel && !penable && !pwrite && hit_dir;
    endsequence

    sequence s_setup_any;
        psel && !penable;
    endsequence

    sequence s_access_done;
        psel && penable && pready;
    endsequence

    property p_dir_read_undef;
        s_setup_rd_dir |=> pready && prdata[7:0] == `BWP_UNDEF_RD;
    endproperty
    a_dir_read_undef: assert property (p_dir_read_undef) // RL1
        else $error("direction read did not return the undefined pattern");

    property p_apb_answer;
        s_setup_any ##1 (psel && penable) |-> pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("slave did not answer in the first access cycle");

    property p_hw_clear;
        hw_standby |=> dir_r == `BWP_RST_DIR && out_r == `BWP_RST_OUT
            && pul_r == `BWP_RST_PUL;
    endproperty
    a_hw_clear: assert property (p_hw_clear) // RL2
        else $error("hardware standby did not clear the port registers");

    property p_gpio_drive;
        (role == BWP_ROLE_GPIO && !freeze && !hw_standby)
            |=> pin_oe == $past(dir_r) && pin_out == $past(out_r);
    endproperty
    a_gpio_drive: assert property (p_gpio_drive) // RL4
        else $error("general I/O pins do not follow direction and latch");

    property p_dbus_drive;
        (role == BWP_ROLE_DBUS && !freeze && !hw_standby)
            |=> pin_oe == {8{$past(ext_data_oe)}} && pin_out == $past(ext_data_out)
            && pin_pullup == 8'h00;
    endproperty
    a_dbus_drive: assert property (p_dbus_drive) // RL5
        else $error("wide bus role does not pass the external data byte");

    property p_out_write;
        (s_access_done and (pwrite && hit_out && pstrb[0] && !freeze && !hw_standby))
            |=> out_r == $past(pwdata[7:0]);
    endproperty
    a_out_write: assert property (p_out_write) // RL6
        else $error("output latch write was lost");

    property p_lvl_write_ignored;
        (s_access_done and (pwrite && hit_lvl && !hw_standby))
            |=> $stable(dir_r) && $stable(out_r) && $stable(pul_r);
    endproperty
    a_lvl_write_ignored: assert property (p_lvl_write_ignored) // RL7
        else $error("write to the readback register changed state");

    property p_lvl_mux;
        !freeze |=> lvl_r == (($past(dir_r) & $past(out_r))
            | (~$past(dir_r) & $past(pin_s)));
    endproperty
    a_lvl_mux: assert property (p_lvl_mux) // RL8
        else $error("readback does not mix latch and pin by direction");

    property p_freeze_hold;
        freeze |=> $stable(lvl_r) && $stable(pin_pullup) && $stable(pin_oe);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) // RL13
        else $error("state changed during manual reset or software standby");

    property p_pull_gate;
        (role == BWP_ROLE_GPIO && !freeze && !hw_standby)
            |=> pin_pullup == ($past(pul_r) & ~$past(dir_r));
    endproperty
    a_pull_gate: assert property (p_pull_gate) // RL11
        else $error("pull-up not gated by input direction");

    property p_pull_off;
        (hw_standby || role == BWP_ROLE_DBUS) && !freeze |=> pin_pullup == 8'h00;
    endproperty
    a_pull_off: assert property (p_pull_off) // RL12
        else $error("pull-up left on in standby or wide bus role");

    property p_role_follow;
        ($changed(bus_16bit) && ext_mode && !freeze && !hw_standby)
            |=> pin_pullup == ($past(bus_16bit) ? 8'h00 : ($past(pul_r) & ~$past(dir_r)));
    endproperty
    a_role_follow: assert property (p_role_follow) // RL15
        else $error("bus width change not applied on the next cycle");

    property p_unmapped_err;
        (s_setup_any and !hit_any) |=> pslverr && pready;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("unmapped address not answered with an error");

    property p_hw_pins_off;
        hw_standby |=> pin_oe == 8'h00 && pin_pullup == 8'h00;
    endproperty
    a_hw_pins_off: assert property (p_hw_pins_off) // RL12
        else $error("hardware standby left a pin driven or pulled up");

    property p_frozen_write;
        (s_access_done and (pwrite && freeze))
            |=> $stable(dir_r) && $stable(out_r) && $stable(pul_r);
    endproperty
    a_frozen_write: assert property (p_frozen_write) // RL6
        else $error("write during manual reset or software standby changed state");

    property p_prdata_hold;
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold)
        else $error("read data changed without a read setup");

    property p_pready_pulse;
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse)
        else $error("ready stood longer than one cycle");

    property p_ext_in_follow;
        $past(presetn, 3) |-> ext_data_in == $past(pin_in, 3);
    endproperty
    a_ext_in_follow: assert property (p_ext_in_follow) // RL5
        else $error("data byte to the bus controller lags the pins wrongly");

    property p_idle_role;
        (role == BWP_ROLE_IDLE && !freeze) |=> pin_oe == 8'h00 && pin_pullup == 8'h00;
    endproperty
    a_idle_role: assert property (p_idle_role) // RL15
        else $error("unused mode code left a pin driven or pulled up");
endmodule : bwp_port

// File: verilog/bwp_sync2.sv
// Two-stage synchroniser for the port pin levels
`timescale 1ns/1ns
module bwp_sync2 import bwp_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] d,
    output logic [7:0] q
);
    logic [7:0] meta_r;
    logic [7:0] q_r;

    // One synchroniser per pin bit
    for (genvar i = 0; i < 8; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_r[i] <= 1'b0;
                q_r[i] <= 1'b0;
            end else begin
                meta_r[i] <= d[i];
                q_r[i] <= meta_r[i];
            end
        end
    end

    assign q = q_r;
endmodule : bwp_sync2
